//--- design/dmo_addr.sv
// Operand address resolution and data memory decode for the core
// Summary of operation
// - Four blocks: internal RAM, function space, auxiliary and module RAM.
// - Bytes 0 to 31 hold four banks of eight registers, one active.
// - Bytes 20h to 2Fh give bit addresses 00 to 7F in order.
// - The stack may sit anywhere in the 256-byte internal RAM.
// - Auxiliary RAM via pointer and buffer; the pointer post-increments.
// - When enabled, auxiliary RAM answers external moves at FF00 to FFFF.
// - When disabled, auxiliary RAM leaves FF00 to FFFF to others.
// - Module RAM sits where the decode logic array places it.
// - Function registers: direct, bit or register-specific addressing only, 80h to FFh.
// - Function registers ending in 0h or 8h are also bit-addressable.
// - Direct operand: 8-bit field reaching internal RAM and function space.
// - 8-bit indirect address from register 0, register 1 or stack pointer.
// - 16-bit indirect address comes only from the wide data pointer.
// - Register mode uses 3-bit field; bank from status word bank bits.
// - Register-specific operand implied by opcode; no address byte.
// - Immediate constants come from program memory after the opcode.
// - Indexed reads program memory only, at accumulator plus 16-bit base.
// - Bank bits pick bank 0 to 3 at 00h, 08h, 10h, 18h.
// - Stack pointer increments before push stores and resets to 07h.
`timescale 1ns/1ps
module dmo_addr #(
  parameter int MOD_DEPTH = 8192
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_req,
  input wire dmo_pkg::dmo_mode_type i_mode,
  input wire logic i_we,
  input wire logic [7:0] i_addr,
  input wire logic [2:0] i_reg_sel,
  input wire logic [1:0] i_ptr_sel,
  input wire logic [7:0] i_ext_page,
  input wire logic [7:0] i_wdata,
  input wire logic [15:0] i_pc,
  input wire logic i_aux_en,
  input wire logic i_mod_en,
  input wire logic [2:0] i_mod_base,
  output logic o_ack,
  output logic [7:0] o_rdata,
  output logic o_bit,
  output logic o_ext_miss,
  output logic [15:0] o_ext_addr,
  output logic o_prog_rd,
  output logic [15:0] o_prog_addr,
  output logic o_err
);
  generate
    if (MOD_DEPTH != dmo_pkg::MOD_BYTES) begin : g_bad_depth
      $error("Module RAM depth must be 8 Kbytes");
    end
  endgenerate

  // Separate storage blocks
  logic [7:0] iram_q [dmo_pkg::IRAM_BYTES];
  logic [7:0] sfr_q [dmo_pkg::SFR_BYTES];
  logic [7:0] aux_q [dmo_pkg::AUX_BYTES];
  logic [7:0] mod_q [MOD_DEPTH];

  logic ack_q;
  logic [7:0] rdata_q;
  logic bit_q;
  logic ext_miss_q;
  logic [15:0] ext_addr_q;
  logic prog_rd_q;
  logic [15:0] prog_addr_q;
  logic err_q;

  // Core registers held in function register space
  wire [7:0] status_w = sfr_q[dmo_pkg::SFR_STATUS[6:0]];
  wire [1:0] bank_w = status_w[dmo_pkg::STATUS_BANK_LSB +: 2];
  wire [7:0] sp_w = sfr_q[dmo_pkg::SFR_SP[6:0]];
  wire [7:0] acc_w = sfr_q[dmo_pkg::SFR_ACC[6:0]];
  wire [7:0] aux_ptr_w = sfr_q[dmo_pkg::SFR_AUX_PTR[6:0]];
  wire [15:0] wide_data_pointer_w = {sfr_q[dmo_pkg::SFR_DPH[6:0]],
                        sfr_q[dmo_pkg::SFR_DPL[6:0]]};

  wire is_dir = i_mode == dmo_pkg::DMO_DIRECT;
  wire is_ind8 = i_mode == dmo_pkg::DMO_IND8;
  wire is_ext16 = i_mode == dmo_pkg::DMO_EXT16;
  wire is_ext8 = i_mode == dmo_pkg::DMO_EXT8;
  wire is_reg = i_mode == dmo_pkg::DMO_REG;
  wire is_rspec = i_mode == dmo_pkg::DMO_REGSPEC;
  wire is_imm = i_mode == dmo_pkg::DMO_IMM;
  wire is_idxd = i_mode == dmo_pkg::DMO_IDX_WIDE_DATA_POINTER;
  wire is_idxp = i_mode == dmo_pkg::DMO_IDX_PC;
  wire is_bit = i_mode == dmo_pkg::DMO_BIT;
  wire is_push = i_mode == dmo_pkg::DMO_PUSH;
  wire is_pop = i_mode == dmo_pkg::DMO_POP;
  wire is_ext = is_ext16 | is_ext8;
  wire is_prog = is_imm | is_idxd | is_idxp;

  // Working register of the active bank, bank bits on top
  wire [7:0] reg_addr = {3'h0, bank_w,
                         i_reg_sel};
  wire [7:0] wr0_w = iram_q[{3'h0, bank_w, 3'h0}];
  wire [7:0] wr1_w = iram_q[{3'h0, bank_w, 3'h1}];
  // Pointer for 8-bit indirect access
  wire [7:0] ptr8 = (i_ptr_sel == 2'h0) ? wr0_w :
                    (i_ptr_sel == 2'h1) ? wr1_w : sp_w;
  wire [7:0] sp_inc = sp_w + 8'h01;
  wire [7:0] sp_dec = sp_w - 8'h01;

  // Opcode-implied register: 0 acc, 1 low pointer, 2 high pointer, else sp
  wire [7:0] rspec_addr = (i_reg_sel == 3'h0) ? dmo_pkg::SFR_ACC :
                          (i_reg_sel == 3'h1) ? dmo_pkg::SFR_DPL :
                          (i_reg_sel == 3'h2) ? dmo_pkg::SFR_DPH :
                          dmo_pkg::SFR_SP;

  // Bit address to byte address
  wire [7:0] bit_byte = i_addr[7] ? {i_addr[7:3], 3'h0}
                      : dmo_pkg::BIT_AREA_BASE
                        + {4'h0, i_addr[6:3]};

  wire [7:0] int_addr = (is_dir) ? i_addr :
                        (is_bit) ? bit_byte :
                        (is_ind8) ? ptr8 :
                        (is_reg) ? reg_addr :
                        (is_rspec) ? rspec_addr :
                        (is_push) ? sp_inc : sp_w;

  // Function space only by direct, bit or register-specific form; indirect upper half is RAM
  wire in_sfr = ((is_dir | is_bit) & i_addr[7])
              | is_rspec;
  wire is_int = is_dir | is_bit | is_ind8 | is_reg | is_rspec |
                is_push | is_pop;
  wire buf_hit = is_dir & (i_addr == dmo_pkg::SFR_AUX_BUF);

  // External data moves
  wire [15:0] ext_addr = is_ext16 ? wide_data_pointer_w
                       : {i_ext_page, ptr8};
  wire aux_hit = is_ext & i_aux_en &
                 (ext_addr[15:8] == dmo_pkg::AUX_WINDOW_HI);
  wire mod_hit = is_ext & ~aux_hit & i_mod_en &
                 (ext_addr[15:13] == i_mod_base);
  wire ext_miss = is_ext & ~aux_hit & ~mod_hit;

  wire [7:0] int_byte = buf_hit ? aux_q[aux_ptr_w] :
                        in_sfr ? sfr_q[int_addr[6:0]] : iram_q[int_addr];
  wire [7:0] ext_byte = aux_hit ? aux_q[ext_addr[7:0]] :
                        mod_hit ? mod_q[ext_addr[12:0]] : 8'h00;
  wire [7:0] cur_byte = is_ext ? ext_byte : int_byte;

  // Bit read and read-modify-write
  wire [2:0] bit_pos = i_addr[2:0];
  wire [7:0] bit_mask = 8'h01 << bit_pos;
  wire bit_val = cur_byte[bit_pos];
  wire [7:0] bit_set = i_wdata[0] ? bit_mask : 8'h00;
  wire [7:0] bit_new = (cur_byte & ~bit_mask) | bit_set;
  wire [7:0] wr_byte = is_bit ? bit_new : i_wdata;

  // Program memory address: constant after opcode or table entry
  wire [15:0] imm_step = {15'h0, i_reg_sel[0]} + 16'h0001;
  wire [15:0] prog_imm = i_pc + imm_step;
  wire [15:0] idx_base = is_idxd ? wide_data_pointer_w : i_pc;
  wire [15:0] prog_idx = idx_base + {8'h00, acc_w};
  wire [15:0] prog_addr = is_imm ? prog_imm : prog_idx;

  // Writes; program memory is never written
  wire wr_int = i_req & is_int & ~is_pop & (i_we | is_push);
  wire wr_sfr = wr_int & in_sfr & ~buf_hit;
  wire wr_iram = wr_int & ~in_sfr;
  wire wr_buf = wr_int & buf_hit;
  wire wr_aux = (i_req & i_we & aux_hit) | wr_buf;
  wire [7:0] aux_wa = buf_hit ? aux_ptr_w : ext_addr[7:0];
  wire wr_mod = i_req & i_we & mod_hit;
  wire sp_step = i_req & (is_push | is_pop);
  wire [7:0] sp_next = is_push ? sp_inc : sp_dec;
  wire ptr_step = i_req & buf_hit;

  always_ff @(posedge i_mclk) begin
    if (wr_iram) begin
      iram_q[int_addr] <= wr_byte;
    end
    if (wr_aux) begin
      aux_q[aux_wa] <= wr_byte;
    end
    if (wr_mod) begin
      mod_q[ext_addr[12:0]] <= wr_byte;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      for (int k = 0; k < dmo_pkg::SFR_BYTES; k++) begin
        sfr_q[k] <= dmo_pkg::SFR_RESET;
      end
      sfr_q[dmo_pkg::SFR_SP[6:0]] <= dmo_pkg::SP_RESET;
    end else begin
      if (wr_sfr) begin
        sfr_q[int_addr[6:0]] <= wr_byte;
      end
      if (sp_step) begin
        sfr_q[dmo_pkg::SFR_SP[6:0]] <= sp_next;
      end
      if (ptr_step) begin
        sfr_q[dmo_pkg::SFR_AUX_PTR[6:0]] <= aux_ptr_w + 8'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      bit_q <= 1'b0;
      ext_miss_q <= 1'b0;
      ext_addr_q <= 16'h0000;
      prog_rd_q <= 1'b0;
      prog_addr_q <= 16'h0000;
      err_q <= 1'b0;
    end else begin
      ack_q <= i_req;
      rdata_q <= i_req ? cur_byte : rdata_q;
      bit_q <= i_req ? bit_val : bit_q;
      ext_miss_q <= i_req & ext_miss;
      ext_addr_q <= (i_req & is_ext) ? ext_addr : ext_addr_q;
      prog_rd_q <= i_req & is_prog;
      prog_addr_q <= (i_req & is_prog) ? prog_addr : prog_addr_q;
      err_q <= i_req & is_prog & i_we;
    end
  end

  assign o_ack = ack_q;
  assign o_rdata = rdata_q;
  assign o_bit = bit_q;
  assign o_ext_miss = ext_miss_q;
  assign o_ext_addr = ext_addr_q;
  assign o_prog_rd = prog_rd_q;
  assign o_prog_addr = prog_addr_q;
  assign o_err = err_q;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  wire [7:0] reg_byte_w = iram_q[reg_addr];
  wire [7:0] sfr_dir_w = sfr_q[i_addr[6:0]];
  wire [7:0] bit_area_w = iram_q[dmo_pkg::BIT_AREA_BASE + {4'h0, i_addr[6:3]}];
  wire [15:0] idx_sum_w = wide_data_pointer_w + {8'h00, acc_w};
  wire [15:0] pc_sum_w = i_pc + {8'h00, acc_w};
  wire [7:0] stack_top_w = iram_q[sp_w];
  wire [7:0] ind_byte_w = iram_q[ptr8];
  wire [7:0] buf_byte_w = aux_q[aux_ptr_w];
  wire [7:0] sfr_bit_w = sfr_q[{i_addr[6:3], 3'h0}];
  logic rst_seen_q;
  always_ff @(posedge i_mclk) begin
    rst_seen_q <= i_resetn;
  end

  a_sp_after_reset: assert property (
    !rst_seen_q |-> sp_w == 8'h07)
    else $error("Stack pointer not 07h after reset");

  a_push_preinc: assert property (
    i_req && is_push |=> sp_w == $past(sp_inc) &&
    stack_top_w == $past(i_wdata))
    else $error("Push did not pre-increment the stack pointer");

  a_pop_postdec: assert property (
    i_req && is_pop |=> sp_w == $past(sp_dec) &&
    o_rdata == $past(stack_top_w))
    else $error("Pop did not read the top and step the pointer down");

  a_reg_bank_read: assert property (
    i_req && is_reg && !i_we |=> o_ack && o_rdata == $past(reg_byte_w))
    else $error("Register read not from active bank");

  a_bit_area_map: assert property (
    i_req && is_bit && !i_addr[7] |=> o_bit == $past(bit_area_w[bit_pos]))
    else $error("Bit address maps to wrong RAM bit");

  a_sfr_bit_map: assert property (
    i_req && is_bit && i_addr[7] |=> o_bit == $past(sfr_bit_w[bit_pos]))
    else $error("Upper bit address maps to wrong function bit");

  a_aux_window_hit: assert property (
    i_req && is_ext && i_aux_en && ext_addr[15:8] == 8'hff |=> !o_ext_miss)
    else $error("Auxiliary RAM did not claim its window");

  a_aux_off_miss: assert property (
    i_req && is_ext && !i_aux_en && !mod_hit |=> o_ext_miss && o_ack)
    else $error("Disabled auxiliary RAM still answered");

  a_miss_idle: assert property (
    !(i_req && is_ext) |=> !o_ext_miss)
    else $error("Miss flag raised without an external access");

  a_mod_claim: assert property (
    i_req && is_ext16 && i_mod_en && wide_data_pointer_w[15:13] == i_mod_base &&
    !(i_aux_en && wide_data_pointer_w[15:8] == 8'hff) |=> !o_ext_miss)
    else $error("Module RAM did not claim its placed window");

  a_ext16_addr: assert property (
    i_req && is_ext16 |=> o_ext_addr == $past(wide_data_pointer_w))
    else $error("Wide external address not from data pointer");

  a_ptr_post_inc: assert property (
    i_req && buf_hit |=> aux_ptr_w == $past(aux_ptr_w) + 8'h01)
    else $error("Auxiliary pointer did not post-increment");

  a_buf_read_ptr: assert property (
    i_req && buf_hit |=> o_rdata == $past(buf_byte_w))
    else $error("Data buffer did not read at the pointer");

  a_direct_sfr_read: assert property (
    i_req && is_dir && i_addr[7] && !buf_hit |=> o_rdata == $past(sfr_dir_w))
    else $error("Direct upper address did not reach function space");

  a_ind8_upper_ram: assert property (
    i_req && is_ind8 |=> o_rdata == $past(ind_byte_w))
    else $error("Indirect access did not read internal RAM");

  a_regspec_acc: assert property (
    i_req && is_rspec && i_reg_sel == 3'h0 |=> o_rdata == $past(acc_w))
    else $error("Register-specific read did not reach accumulator");

  a_indexed_sum: assert property (
    i_req && is_idxd |=> o_prog_rd && o_prog_addr == $past(idx_sum_w))
    else $error("Indexed address is not accumulator plus pointer");

  a_idx_pc_sum: assert property (
    i_req && is_idxp |=> o_prog_rd && o_prog_addr == $past(pc_sum_w))
    else $error("Indexed address is not accumulator plus counter");

  a_imm_addr: assert property (
    i_req && is_imm |=> o_prog_rd &&
    o_prog_addr == $past(i_pc) + 16'h0001 + {15'h0, $past(i_reg_sel[0])})
    else $error("Immediate fetch address not after the opcode");

  a_prog_no_write: assert property (
    i_req && is_prog && i_we |=> o_err && o_prog_rd)
    else $error("Program memory write not flagged");

  a_err_idle: assert property (
    !(i_req && is_prog && i_we) |=> !o_err)
    else $error("Error flag raised without a refused write");

  a_ack_pulse: assert property (
    i_req |=> o_ack)
    else $error("Access not acknowledged one cycle later");

  a_ack_idle: assert property (
    !i_req |=> !o_ack)
    else $error("Acknowledge raised without a request");
endmodule

//--- design/dmo_pkg.sv
// Constants and types shared by the operand addressing block
package dmo_pkg;
  localparam int IRAM_BYTES = 256;
  localparam int SFR_BYTES = 128;
  localparam int AUX_BYTES = 256;
  localparam int MOD_BYTES = 8192;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_AUX_PTR = 8'h9d;
  localparam logic [7:0] SFR_AUX_BUF = 8'h9e;
  localparam logic [7:0] SFR_STATUS = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam int STATUS_BANK_LSB = 3;
  localparam logic [7:0] AUX_WINDOW_HI = 8'hff;
  localparam logic [7:0] SFR_RESET = 8'h00;

  typedef enum logic [3:0] {
    DMO_DIRECT = 4'h0,
    DMO_IND8 = 4'h1,
    DMO_EXT16 = 4'h2,
    DMO_EXT8 = 4'h3,
    DMO_REG = 4'h4,
    DMO_REGSPEC = 4'h5,
    DMO_IMM = 4'h6,
    DMO_IDX_WIDE_DATA_POINTER = 4'h7,
    DMO_IDX_PC = 4'h8,
    DMO_BIT = 4'h9,
    DMO_PUSH = 4'ha,
    DMO_POP = 4'hb
  } dmo_mode_type;
endpackage

//--- dv/dmo_core_model.sv
// Core-side model that issues one operand access at a time
`timescale 1ns/1ps
module dmo_core_model (
  input wire logic i_mclk,
  output logic o_req = 1'b0,
  output dmo_pkg::dmo_mode_type o_mode = dmo_pkg::DMO_DIRECT,
  output logic o_we = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [2:0] o_reg_sel = 3'h0,
  output logic [1:0] o_ptr_sel = 2'h0,
  output logic [7:0] o_ext_page = 8'hff,
  output logic [7:0] o_wdata = 8'h00,
  output logic [15:0] o_pc = 16'h0100,
  output logic o_aux_en = 1'b0,
  output logic o_mod_en = 1'b0,
  output logic [2:0] o_mod_base = 3'h0
);
  // One-cycle request; answer is due one edge later
  task automatic access(input dmo_pkg::dmo_mode_type m, input logic w,
    input logic [7:0] a, input logic [2:0] s, input logic [7:0] d);
    @(posedge i_mclk);
    o_req <= 1'b1;
    o_mode <= m;
    o_we <= w;
    o_addr <= a;
    o_reg_sel <= s;
    o_ptr_sel <= s[1:0];
    o_wdata <= d;
    @(posedge i_mclk);
    o_req <= 1'b0;
    // Released address and data lines do not keep the last value
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the operand addressing block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req, we, ack, bitv, miss, prd, err, aux, men;
  dmo_pkg::dmo_mode_type mode;
  logic [7:0] addr, wdata, page, rdata;
  logic [2:0] rsel, mbase;
  logic [1:0] psel;
  logic [15:0] pc, eaddr, paddr;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  dmo_core_model core (.i_mclk(clk), .o_req(req), .o_mode(mode), .o_we(we),
    .o_addr(addr), .o_reg_sel(rsel), .o_ptr_sel(psel), .o_ext_page(page),
    .o_wdata(wdata), .o_pc(pc), .o_aux_en(aux), .o_mod_en(men),
    .o_mod_base(mbase));
  dmo_addr DUT (.i_mclk(clk), .i_resetn(rst_n), .i_req(req), .i_mode(mode),
    .i_we(we), .i_addr(addr), .i_reg_sel(rsel), .i_ptr_sel(psel),
    .i_ext_page(page), .i_wdata(wdata), .i_pc(pc), .i_aux_en(aux),
    .i_mod_en(men), .i_mod_base(mbase), .o_ack(ack), .o_rdata(rdata),
    .o_bit(bitv), .o_ext_miss(miss), .o_ext_addr(eaddr), .o_prog_rd(prd),
    .o_prog_addr(paddr), .o_err(err));
  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input dmo_pkg::dmo_mode_type m, input logic w,
    input logic [7:0] a, input logic [2:0] s, input logic [7:0] d);
    core.access(m, w, a, s, d);
    chk("ack", 16'h1, {15'h0, ack});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(dmo_pkg::DMO_DIRECT, 1'b1, a, 3'h0, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(dmo_pkg::DMO_DIRECT, 1'b0, a, 3'h0, 8'h00);
    chk("rdata", {8'h0, e}, {8'h0, rdata});
  endtask
  task automatic t_stack();
    rd(8'h81, 8'h07);
    op(dmo_pkg::DMO_PUSH, 1'b1, 8'h00, 3'h0, 8'h3c);
    rd(8'h08, 8'h3c);
    rd(8'h81, 8'h08);
    op(dmo_pkg::DMO_POP, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("pop", 16'h3c, {8'h0, rdata});
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b << 3));
      op(dmo_pkg::DMO_REG, 1'b1, 8'h00, 3'h1, 8'(8'h40 + b));
      rd(8'(b * 8 + 1), 8'(8'h40 + b));
    end
    wr(8'hd0, 8'h00);
    op(dmo_pkg::DMO_REG, 1'b0, 8'h00, 3'h1, 8'h00);
    chk("reg", 16'h40, {8'h0, rdata});
  endtask
  task automatic t_bits();
    wr(8'h21, 8'h04);
    op(dmo_pkg::DMO_BIT, 1'b0, 8'h0a, 3'h0, 8'h00);
    chk("bit", 16'h1, {15'h0, bitv});
    op(dmo_pkg::DMO_BIT, 1'b0, 8'h0b, 3'h0, 8'h00);
    chk("bit", 16'h0, {15'h0, bitv});
    op(dmo_pkg::DMO_BIT, 1'b1, 8'he3, 3'h0, 8'h01);
    rd(8'he0, 8'h08);
  endtask
  task automatic t_ext();
    core.o_aux_en <= 1'b1;
    wr(8'h9d, 8'h10);
    wr(8'h9e, 8'ha5);
    rd(8'h9d, 8'h11);
    wr(8'h82, 8'h10);
    wr(8'h83, 8'hff);
    op(dmo_pkg::DMO_EXT16, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("ext16", 16'ha5, {8'h0, rdata});
    chk("ext_addr", 16'hff10, eaddr);
    wr(8'h00, 8'h10);
    op(dmo_pkg::DMO_EXT8, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("ext8", 16'ha5, {8'h0, rdata});
    core.o_aux_en <= 1'b0;
    op(dmo_pkg::DMO_EXT16, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("miss", 16'h1, {15'h0, miss});
    core.o_mod_en <= 1'b1;
    core.o_mod_base <= 3'h7;
    op(dmo_pkg::DMO_EXT16, 1'b1, 8'h00, 3'h0, 8'h5a);
    op(dmo_pkg::DMO_EXT16, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("mod", 16'h5a, {8'h0, rdata});
    chk("miss", 16'h0, {15'h0, miss});
  endtask
  task automatic t_prog();
    wr(8'he0, 8'h05);
    op(dmo_pkg::DMO_IDX_WIDE_DATA_POINTER, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("prog_rd", 16'h1, {15'h0, prd});
    chk("prog_addr", 16'hff15, paddr);
    op(dmo_pkg::DMO_IDX_PC, 1'b0, 8'h00, 3'h0, 8'h00);
    chk("prog_addr", 16'h0105, paddr);
    op(dmo_pkg::DMO_IDX_PC, 1'b1, 8'h00, 3'h0, 8'h00);
    chk("err", 16'h1, {15'h0, err});
    op(dmo_pkg::DMO_IMM, 1'b0, 8'h00, 3'h1, 8'h00);
    chk("prog_addr", 16'h0102, paddr);
    op(dmo_pkg::DMO_REGSPEC, 1'b0, 8'h00, 3'h1, 8'h00);
    chk("regspec", 16'h10, {8'h0, rdata});
  endtask
  task automatic t_upper();
    wr(8'h01, 8'h90);
    op(dmo_pkg::DMO_IND8, 1'b1, 8'h00, 3'h1, 8'h77);
    rd(8'h90, 8'h00);
    op(dmo_pkg::DMO_IND8, 1'b0, 8'h00, 3'h1, 8'h00);
    chk("ind8", 16'h77, {8'h0, rdata});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_stack();
    t_banks();
    t_bits();
    t_ext();
    t_prog();
    t_upper();
    results();
  end
endmodule
